/* File: logic/rtp_defines.vh */
// Constants shared by the real-time clock two-wire target port
`ifndef RTP_DEFINES_VH
`define RTP_DEFINES_VH

// Fixed seven-bit bus address; D0h writes, D1h reads
`define RTP_DEV_ADDR 7'h68
// Direction bit value that selects a read
`define RTP_DIR_READ 1'b1
// Acknowledge level on the data line
`define RTP_ACK_LVL 1'b0
// Data bits in one byte
`define RTP_BYTE_BITS 4'h8
// Bit counter clear value
`define RTP_CNT_ZERO 4'h0
// Bit counter step
`define RTP_CNT_ONE 4'h1
// Address counter value after reset
`define RTP_PTR_RST 8'h00
// Address counter step
`define RTP_PTR_ONE 8'h01
// Level driven on the open-drain data pin when enabled
`define RTP_SDA_DRIVE 1'b0
// Write queue geometry: pointer plus data, sixteen entries
`define RTP_FIFO_WIDTH 16
`define RTP_FIFO_DEPTH 16
`define RTP_FIFO_AW 4
// Byte kinds received from the controller
`define RTP_KIND_ADDR 2'h0
`define RTP_KIND_PTR 2'h1
`define RTP_KIND_DATA 2'h2

`endif

/* File: logic/rtp_fifo.v */
// Synchronous FIFO with valid/ready on both sides
module rtp_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire sys_clk_i,
	input wire rst_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	// Full and empty come straight from the occupancy count
	assign in_ready_o = (count_r != DEPTH[AW:0]);
	assign out_valid_o = (count_r != {(AW+1){1'b0}});
	assign out_data_o = mem_r[rd_ptr_r];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Storage write
	always @(posedge sys_clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	// Pointers and count; depth is a power of two so pointers wrap freely
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push & ~pop) begin
				count_r <= count_r + {{AW{1'b0}}, 1'b1};
			end else if (pop & ~push) begin
				count_r <= count_r - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule

/* File: logic/rtp_i2c_target.v */
// Two-wire target port of the real-time clock: address match, pointer, write queue, reads
`include "rtp_defines.vh"

module rtp_i2c_target (
	input wire sys_clk_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_n_o,
	output wire wr_valid_o,
	input wire wr_ready_i,
	output wire [7:0] wr_addr_o,
	output wire [7:0] wr_data_o,
	output wire [7:0] rd_addr_o,
	input wire [7:0] rd_data_i,
	output wire rd_take_o,
	output wire busy_o
);

	localparam [2:0] ST_IDLE = 3'b000;
	localparam [2:0] ST_RX = 3'b001;
	localparam [2:0] ST_ACK = 3'b010;
	localparam [2:0] ST_TX = 3'b011;
	localparam [2:0] ST_MACK = 3'b100;
	localparam [2:0] ST_IGNORE = 3'b101;

	// Pin synchronisers and edge history
	reg scl_s1_r;
	reg scl_s2_r;
	reg scl_d_r;
	reg sda_s1_r;
	reg sda_s2_r;
	reg sda_d_r;

	// Protocol state
	reg [2:0] state_r;
	reg [1:0] kind_r;
	reg [3:0] cnt_r;
	reg [7:0] rx_sh_r;
	reg [7:0] tx_sh_r;
	reg [7:0] ptr_r;
	reg drive_low_r;
	reg ack_given_r;
	reg rd_mode_r;
	reg mack_r;
	reg take_r;
	reg push_r;
	reg [15:0] push_data_r;

	wire scl_rise;
	wire scl_fall;
	wire start_cond;
	wire stop_cond;
	wire fifo_in_ready;
	wire [15:0] fifo_out_data;

	// Address byte decode, used when acking and when picking direction
	function addr_match;
		input [7:0] byte_in;
		begin
			addr_match = (byte_in[7:1] == `RTP_DEV_ADDR);
		end
	endfunction

	// Two flops on each pin before anything looks at it
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
		end
	end

	// Clock edges and START/STOP conditions found by oversampling both pins
	assign scl_rise = scl_s2_r & ~scl_d_r;
	assign scl_fall = ~scl_s2_r & scl_d_r;
	assign start_cond = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign stop_cond = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	// Main protocol engine; START and STOP override every state
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			kind_r <= `RTP_KIND_ADDR;
			cnt_r <= `RTP_CNT_ZERO;
			rx_sh_r <= 8'h00;
			tx_sh_r <= 8'h00;
			ptr_r <= `RTP_PTR_RST;
			drive_low_r <= 1'b0;
			ack_given_r <= 1'b0;
			rd_mode_r <= 1'b0;
			mack_r <= 1'b0;
			take_r <= 1'b0;
			push_r <= 1'b0;
			push_data_r <= 16'h0000;
		end else begin
			take_r <= 1'b0;
			push_r <= 1'b0;
			if (start_cond) begin
				state_r <= ST_RX;
				kind_r <= `RTP_KIND_ADDR;
				cnt_r <= `RTP_CNT_ZERO;
				drive_low_r <= 1'b0;
			end else if (stop_cond) begin
				state_r <= ST_IDLE;
				drive_low_r <= 1'b0;
			end else begin
				case (state_r)
				ST_RX: begin
					if (scl_rise) begin
						rx_sh_r <= {rx_sh_r[6:0], sda_s2_r};
						cnt_r <= cnt_r + `RTP_CNT_ONE;
					end else if (scl_fall && cnt_r == `RTP_BYTE_BITS) begin
						cnt_r <= `RTP_CNT_ZERO;
						state_r <= ST_ACK;
						if (kind_r == `RTP_KIND_ADDR) begin
							if (addr_match(rx_sh_r)) begin
								drive_low_r <= 1'b1;
								ack_given_r <= 1'b1;
								rd_mode_r <= (rx_sh_r[0] == `RTP_DIR_READ);
								if (rx_sh_r[0] == `RTP_DIR_READ) begin
									tx_sh_r <= rd_data_i;
									take_r <= 1'b1;
									ptr_r <= ptr_r + `RTP_PTR_ONE;
								end
							end else begin
								drive_low_r <= 1'b0;
								ack_given_r <= 1'b0;
								rd_mode_r <= 1'b0;
							end
						end else if (kind_r == `RTP_KIND_PTR) begin
							ptr_r <= rx_sh_r;
							drive_low_r <= 1'b1;
							ack_given_r <= 1'b1;
						end else begin
							if (fifo_in_ready) begin
								push_r <= 1'b1;
								push_data_r <= {ptr_r, rx_sh_r};
								ptr_r <= ptr_r + `RTP_PTR_ONE;
								drive_low_r <= 1'b1;
								ack_given_r <= 1'b1;
							end else begin
								// Queue full: no clock stretching, so refuse with NACK
								drive_low_r <= 1'b0;
								ack_given_r <= 1'b0;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (!ack_given_r) begin
							drive_low_r <= 1'b0;
							state_r <= ST_IGNORE;
						end else if (rd_mode_r && kind_r == `RTP_KIND_ADDR) begin
							drive_low_r <= ~tx_sh_r[7];
							state_r <= ST_TX;
						end else begin
							drive_low_r <= 1'b0;
							state_r <= ST_RX;
							kind_r <= (kind_r == `RTP_KIND_ADDR) ? `RTP_KIND_PTR : `RTP_KIND_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + `RTP_CNT_ONE;
					end else if (scl_fall) begin
						if (cnt_r == `RTP_BYTE_BITS) begin
							// Release for the controller's ninth bit
							drive_low_r <= 1'b0;
							cnt_r <= `RTP_CNT_ZERO;
							state_r <= ST_MACK;
						end else begin
							tx_sh_r <= {tx_sh_r[6:0], 1'b0};
							drive_low_r <= ~tx_sh_r[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_r <= (sda_s2_r == `RTP_ACK_LVL);
					end else if (scl_fall) begin
						if (mack_r) begin
							tx_sh_r <= rd_data_i;
							take_r <= 1'b1;
							ptr_r <= ptr_r + `RTP_PTR_ONE;
							drive_low_r <= ~rd_data_i[7];
							state_r <= ST_TX;
						end else begin
							drive_low_r <= 1'b0;
							state_r <= ST_IGNORE;
						end
					end
				end
				ST_IGNORE: begin
					drive_low_r <= 1'b0;
				end
				default: begin
					drive_low_r <= 1'b0;
					state_r <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// Open-drain data pin: enable is low only while pulling low
	assign sda_o = `RTP_SDA_DRIVE;
	assign sda_oe_n_o = ~drive_low_r;
	// clock is input only, never driven
	assign rd_addr_o = ptr_r;
	assign rd_take_o = take_r;
	assign busy_o = (state_r != ST_IDLE) && (state_r != ST_IGNORE);
	assign wr_addr_o = fifo_out_data[15:8];
	assign wr_data_o = fifo_out_data[7:0];

	// Written bytes queue up so the register side may stall
	rtp_fifo #(
		.WIDTH(`RTP_FIFO_WIDTH),
		.DEPTH(`RTP_FIFO_DEPTH),
		.AW(`RTP_FIFO_AW)
	) u_wr_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.in_valid_i(push_r),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_data_r),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(fifo_out_data)
	);

endmodule

/* File: test/rtp_i2c_target_props.sv */
// Checker for the target port pins, address counter and write queue
module rtp_i2c_target_props (
	input wire sys_clk_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_n_o,
	input wire wr_valid_o,
	input wire wr_ready_i,
	input wire [7:0] wr_addr_o,
	input wire [7:0] wr_data_o,
	input wire [7:0] rd_addr_o,
	input wire rd_take_o,
	input wire busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// A drive on the data pin starts, then must last at least eight clock cycles
	sequence drive_go; $fell(sda_oe_n_o); endsequence
	sequence drive_held; !sda_oe_n_o [*8]; endsequence
	// A drive must both select the low level and really pull the shared line down
	drive_lvl_a: assert property (!sda_oe_n_o |-> sda_o == 1'b0 && !sda_i) else $error("pin drive level not low");
	bit_hold_a: assert property (drive_go |-> drive_held) else $error("pin drive too short");
	edge_low_a: assert property (!$stable(sda_oe_n_o) |-> !scl_i) else $error("drive change with clock high");
	idle_quiet_a: assert property (!busy_o |-> sda_oe_n_o) else $error("pin driven while idle");
	take_one_a: assert property (rd_take_o |=> !rd_take_o) else $error("fetch pulse too long");
	// Two cycles back covers an advance on either edge around the pulse
	take_step_a: assert property (rd_take_o |=> rd_addr_o == $past(rd_addr_o, 2) + 8'h01)
		else $error("counter not advanced on fetch");
	head_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_addr_o, wr_data_o}))
		else $error("queue head lost while stalled");
	push_addr_a: assert property ($rose(wr_valid_o) |-> rd_addr_o == wr_addr_o + 8'h01)
		else $error("counter not one past stored byte");
endmodule

bind rtp_i2c_target rtp_i2c_target_props chk (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
	.wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_take_o(rd_take_o),
	.busy_o(busy_o)
);

/* File: test/rtp_ctrl_model.sv */
// Bus controller model that drives clock and data of the two-wire link
module rtp_ctrl_model (
	output logic scl_o,
	output logic sda_o,
	input wire logic line_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus: clock still and data released to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic cond(input logic s);
		#8 sda_o = s;
		#16 scl_o = 1'b1;
		#16 sda_o = !s;
		#16 scl_o = !s;
		#24;
	endtask
	task automatic bit_x(input logic b, output logic r);
		#8 sda_o = b;
		#32 scl_o = 1'b1;
		#16 r = line_i;
		#24 scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
		for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
		bit_x(ai, ao);
	endtask
endmodule

/* File: test/rtp_i2c_target_tb_top.sv */
// Self-checking bench for the two-wire target port
module rtp_i2c_target_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i, rst_i, wr_ready_i, hold, ak;
	logic scl, sda_m, sda_o, sda_oe_n_o, wr_valid_o, rd_take_o, busy_o;
	logic [7:0] wr_addr_o, wr_data_o, rd_addr_o, rx, a, b;
	logic [7:0] mem [256];
	logic [7:0] ref_mem [256];
	logic [15:0] exp_q [$];
	int errors = 0, total_checks = 0;
	// Open-drain line: pull-up unless a party pulls low
	wire sda = sda_m & (sda_oe_n_o | sda_o);
	wire [7:0] rd_data_i = mem[rd_addr_o];
	always #2 sys_clk_i = ~sys_clk_i;
	rtp_i2c_target dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .rd_take_o(rd_take_o),
		.busy_o(busy_o));
	rtp_ctrl_model ctl (.scl_o(scl), .sda_o(sda_m), .line_i(sda));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic print_verdict;
		if (errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Consumer stalls at random, or fully while hold is set
	always @(negedge sys_clk_i) wr_ready_i <= !hold && ($urandom_range(1) == 1);
	// Each queue entry taken is checked against the oldest note
	always @(posedge sys_clk_i) if (!rst_i && wr_valid_o && wr_ready_i) begin
		mem[wr_addr_o] <= wr_data_o;
		// An entry with no note behind it is a mismatch on its own
		if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
		else chk({wr_addr_o, wr_data_o}, exp_q.pop_front());
	end
	task automatic wb(input logic [7:0] v, input logic e);
		ctl.xfer(v, 1'b1, rx, ak);
		chk(ak, e);
	endtask
	task automatic rb(input logic last);
		ctl.xfer(8'hFF, last, rx, ak);
		chk(rx, ref_mem[a]);
		a++;
	endtask
	task automatic wr_run(input logic [7:0] p, input int n, input int stored);
		ctl.cond(1'b1);
		wb(8'hD0, 1'b0);
		wb(p, 1'b0);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			if (i < stored) begin
				ref_mem[8'(p + i)] = b;
				exp_q.push_back({8'(p + i), b});
			end
			wb(b, i >= stored);
		end
		ctl.cond(1'b0);
		hold = 1'b0;
		for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge sys_clk_i);
		if (exp_q.size() > 0) begin
			errors++;
			print_verdict();
		end
	endtask
	initial begin
		sys_clk_i = 1'b0;
		rst_i = 1'b1;
		hold = 1'b0;
		void'($urandom(32'h07FB));
		foreach (mem[i]) mem[i] = 8'($urandom);
		ref_mem = mem;
		repeat (20) @(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		wr_run(8'hFE, 3, 3);
		a = 8'hFE;
		ctl.cond(1'b1);
		wb(8'hD0, 1'b0);
		wb(a, 1'b0);
		ctl.cond(1'b1);
		wb(8'hD1, 1'b0);
		rb(1'b0);
		rb(1'b0);
		rb(1'b1);
		ctl.cond(1'b0);
		ctl.cond(1'b1);
		wb(8'hD1, 1'b0);
		rb(1'b1);
		ctl.cond(1'b0);
		for (int k = 0; k < 4; k++) begin
			do b = 8'($urandom); while (b[7:1] == 7'h68);
			ctl.cond(1'b1);
			wb(b, 1'b1);
			wb(8'h00, 1'b1);
			chk(busy_o, 1'b0);
			ctl.cond(1'b0);
		end
		// Full queue refuses the seventeenth byte
		hold = 1'b1;
		wr_run(8'($urandom), 17, 16);
		print_verdict();
	end
endmodule
